//--- verilog/rrps_pkg.sv
package rrps_pkg;

	// ------------------------------------------------------------
	// Channel count and control field layout
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CTRL_W = 8;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int TOGGLE_SEL_BIT = 6;
	localparam int EN_LEVEL_BIT = 7;

	// ------------------------------------------------------------
	// Mode field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_RX_READY = 2'h0;
	localparam logic [1:0] MODE_RX_ENABLE = 2'h3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [NUM_CH-1:0] PIN_RESET = 4'hf;
	localparam logic LINE_ENABLE_RESET = 1'b0;

	// Pin function selected by the mode field
	typedef enum logic {
		FUNC_RX_READY,
		FUNC_RX_ENABLE
	} rrps_func_t;

endpackage

//--- verilog/rrps_chan.sv
`timescale 1ns/1ns

// Per-channel pin value: pure combinational, registered by the parent
module rrps_chan (
	input rrps_pkg::rrps_func_t func,
	input logic en_level,
	input logic toggle_sel,
	input logic data_ready,
	input logic receiving,
	output logic pin_next
);

	// ------------------------------------------------------------
	// Function select
	// ------------------------------------------------------------
	// Ready output is active low, so a waiting character pulls it low
	always_comb begin
		pin_next = 1'b1;
		case (func)
			rrps_pkg::FUNC_RX_READY: begin
				pin_next = ~data_ready;
			end
			rrps_pkg::FUNC_RX_ENABLE: begin
				if (toggle_sel) begin
					// Asserted while receiving, released otherwise
					pin_next = receiving ? en_level : ~en_level;
				end else begin
					pin_next = en_level;
				end
			end
			default: begin
				pin_next = 1'b1;
			end
		endcase
	end

endmodule

//--- verilog/rrps_pin_select.sv
`timescale 1ns/1ns

// Behaviour
// - Mode 00 gives active-low receiver-ready pins
// - Mode 11 turns pins into receive-enable outputs
// - Ready pin low per channel data status
// - Enable level and behaviour from bits 7:6
// - Toggle select 0: pin equals level bit
// - Toggle select 1: pin toggles around level
module rrps_pin_select (
	input logic clock,
	input logic rst_b,
	input logic [rrps_pkg::CTRL_W-1:0] auto_toggle_ctrl,
	input logic [rrps_pkg::NUM_CH-1:0] rx_data_ready,
	input logic [rrps_pkg::NUM_CH-1:0] rx_receiving,
	output logic [rrps_pkg::NUM_CH-1:0] rx_status_pin,
	output logic line_enable_mode
);

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	// Only 11 selects the enable function; 01 and 10 fall back to ready
	function automatic rrps_pkg::rrps_func_t decode_func(input logic [1:0] mode);
		if (mode == rrps_pkg::MODE_RX_ENABLE) begin
			decode_func = rrps_pkg::FUNC_RX_ENABLE;
		end else begin
			decode_func = rrps_pkg::FUNC_RX_READY;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [rrps_pkg::NUM_CH-1:0] pin;
		logic line_enable;
		logic armed;
	} rrps_state_t;

	rrps_state_t state;
	rrps_state_t next_state;
	rrps_pkg::rrps_func_t func;
	logic [1:0] mode;
	logic en_level;
	logic toggle_sel;
	logic [rrps_pkg::NUM_CH-1:0] pin_next;

	// Control bits come from the UART's own register on this clock: no synchroniser
	assign mode = auto_toggle_ctrl[rrps_pkg::MODE_MSB:rrps_pkg::MODE_LSB];
	assign en_level = auto_toggle_ctrl[rrps_pkg::EN_LEVEL_BIT];
	assign toggle_sel = auto_toggle_ctrl[rrps_pkg::TOGGLE_SEL_BIT];
	assign func = decode_func(mode);

	// ------------------------------------------------------------
	// Channel slices
	// ------------------------------------------------------------
	// Channels share controls but each follows its own status
	genvar ch;
	generate
		for (ch = 0; ch < rrps_pkg::NUM_CH; ch++) begin : g_chan
			rrps_chan u_chan (
				.func(func),
				.en_level(en_level),
				.toggle_sel(toggle_sel),
				.data_ready(rx_data_ready[ch]),
				.receiving(rx_receiving[ch]),
				.pin_next(pin_next[ch])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// One register stage keeps the pins glitch free at the cost of a cycle
	always_comb begin
		next_state = state;
		next_state.pin = pin_next;
		next_state.line_enable = (func == rrps_pkg::FUNC_RX_ENABLE);
		next_state.armed = 1'b1;
	end

	// State register; pins idle high so nothing reads as ready during reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state.pin <= rrps_pkg::PIN_RESET;
			state.line_enable <= rrps_pkg::LINE_ENABLE_RESET;
			state.armed <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flip-flops
	assign rx_status_pin = state.pin;
	assign line_enable_mode = state.line_enable;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// Mode 00 leaves the ready function selected
	property p_ready_on_zero;
		state.armed && (mode == rrps_pkg::MODE_RX_READY) |=> !line_enable_mode;
	endproperty
	a_ready_on_zero: assert property (p_ready_on_zero)
		else $error("mode 00 did not select receiver ready");

	// Mode 11 selects the enable function one cycle later
	property p_enable_on_three;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) |=> line_enable_mode;
	endproperty
	a_enable_on_three: assert property (p_enable_on_three)
		else $error("mode 11 did not select receive enable");

	// Ready pins mirror the inverted data status per channel
	property p_ready_follows_status;
		state.armed && (mode != rrps_pkg::MODE_RX_ENABLE)
			|=> (rx_status_pin == ~$past(rx_data_ready));
	endproperty
	a_ready_follows_status: assert property (p_ready_follows_status)
		else $error("ready pin does not follow receive status");

	// Enable pins ignore data status entirely
	property p_enable_ignores_status;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && !toggle_sel
			&& $stable(auto_toggle_ctrl)
			|=> $stable(rx_status_pin);
	endproperty
	a_enable_ignores_status: assert property (p_enable_ignores_status)
		else $error("enable pin moved with steady control");

	// Static enable holds the level bit on every channel
	property p_static_level;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && !toggle_sel
			|=> (rx_status_pin == {rrps_pkg::NUM_CH{$past(en_level)}});
	endproperty
	a_static_level: assert property (p_static_level)
		else $error("static enable pin differs from level bit");

	// Toggling enable: level while receiving, inverse otherwise
	property p_toggle_level;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && toggle_sel
			|=> (rx_status_pin == (~($past(rx_receiving) ^ {rrps_pkg::NUM_CH{$past(en_level)}})));
	endproperty
	a_toggle_level: assert property (p_toggle_level)
		else $error("toggling enable pin wrong for receive activity");

	// A stop in reception releases the enable on the next cycle
	property p_toggle_release;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && toggle_sel && rx_receiving[0]
			##1 (mode == rrps_pkg::MODE_RX_ENABLE) && toggle_sel && !rx_receiving[0]
			|=> (rx_status_pin[0] == ~$past(en_level))
			&& ($past(rx_status_pin[0]) == $past(en_level, 2));
	endproperty
	a_toggle_release: assert property (p_toggle_release)
		else $error("enable not released after reception ended");

	// Modes 01 and 10 behave as receiver ready
	property p_odd_modes_ready;
		state.armed && ((mode == 2'h1) || (mode == 2'h2))
			|=> !line_enable_mode && (rx_status_pin == ~$past(rx_data_ready));
	endproperty
	a_odd_modes_ready: assert property (p_odd_modes_ready)
		else $error("mode 01 or 10 not treated as receiver ready");

	// ------------------------------------------------------------
	// Cross checks between functions and channels
	// ------------------------------------------------------------
	// Function flag is set by mode 11 alone, one cycle late
	property p_line_enable_exact;
		state.armed
			|=> line_enable_mode == ($past(mode) == rrps_pkg::MODE_RX_ENABLE);
	endproperty
	a_line_enable_exact: assert property (p_line_enable_exact)
		else $error("function flag does not match mode field");

	// Level and toggle bits never change the pin function
	property p_mode_alone;
		state.armed && $stable(mode)
			|=> $stable(line_enable_mode);
	endproperty
	a_mode_alone: assert property (p_mode_alone)
		else $error("function flag moved with mode unchanged");

	// Leaving mode 11 hands the pins back to the ready function
	property p_leave_enable;
		state.armed && line_enable_mode && (mode != rrps_pkg::MODE_RX_ENABLE)
			|=> !line_enable_mode && (rx_status_pin == ~$past(rx_data_ready));
	endproperty
	a_leave_enable: assert property (p_leave_enable)
		else $error("pins not back to receiver ready after mode 11");

	// A shared status path would tie channels 0 and 1 together
	property p_channels_independent;
		state.armed && (mode != rrps_pkg::MODE_RX_ENABLE)
			&& (rx_data_ready[0] != rx_data_ready[1])
			|=> rx_status_pin[0] != rx_status_pin[1];
	endproperty
	a_channels_independent: assert property (p_channels_independent)
		else $error("ready pins of channels 0 and 1 not independent");

	// Low level bit: a receiving channel drives its enable low
	property p_toggle_low_level;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && toggle_sel && !en_level
			&& rx_receiving[2] |=> !rx_status_pin[2];
	endproperty
	a_toggle_low_level: assert property (p_toggle_low_level)
		else $error("low level toggle enable not driven low");

	// High level bit: an idle channel drives its enable low
	property p_toggle_high_level;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && toggle_sel && en_level
			&& !rx_receiving[3] |=> !rx_status_pin[3];
	endproperty
	a_toggle_high_level: assert property (p_toggle_high_level)
		else $error("high level toggle enable not released when idle");

	// Bits 5:2 are spare; only mode and the two upper bits count
	property p_spare_bits_ignored;
		state.armed && (mode == rrps_pkg::MODE_RX_ENABLE) && !toggle_sel
			&& $stable(mode) && $stable(en_level) && $stable(toggle_sel)
			|=> $stable(rx_status_pin);
	endproperty
	a_spare_bits_ignored: assert property (p_spare_bits_ignored)
		else $error("static enable pin moved with spare bits");

endmodule

//--- verification/rrps_src_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Receive status source at the far side of the pins
// ------------------------------------------------------------
// Passes levels straight on; any lag here would blur the latency check
module rrps_src_model (
	input logic [3:0] ready_req,
	input logic [3:0] recv_req,
	output logic [3:0] rx_data_ready,
	output logic [3:0] rx_receiving
);
	// Plain level sources, no timing of their own
	assign rx_data_ready = ready_req;
	assign rx_receiving = recv_req;
endmodule

//--- verification/rrps_pin_select_tb.sv
`timescale 1ns/1ns

module rrps_pin_select_tb;
	logic clock;
	logic rst_b;
	logic [7:0] ctrl;
	logic [3:0] rdy_req, rcv_req, rx_data_ready, rx_receiving, rx_status_pin;
	logic line_enable_mode;
	logic [4:0] exp_q[$];
	logic [4:0] e;
	logic [31:0] seed = 32'h5683d9ab;
	int err_count = 0;
	int n_tests = 0;

	// ------------------------------------------------------------
	// Clock, design and source model
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	rrps_pin_select dut_u (.clock(clock), .rst_b(rst_b), .auto_toggle_ctrl(ctrl),
		.rx_data_ready(rx_data_ready), .rx_receiving(rx_receiving),
		.rx_status_pin(rx_status_pin), .line_enable_mode(line_enable_mode));
	rrps_src_model src_u (.ready_req(rdy_req), .recv_req(rcv_req),
		.rx_data_ready(rx_data_ready), .rx_receiving(rx_receiving));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected {mode flag, pins}; modes 01 and 10 fall back to ready pins
	function automatic logic [4:0] model(input logic [7:0] c, input logic [3:0] r,
		input logic [3:0] v);
		logic [4:0] m;
		m = {1'b0, ~r};
		if (c[1:0] == 2'h3) begin
			m = {1'b1, c[6] ? (v ~^ {4{c[7]}}) : {4{c[7]}}};
		end
		return m;
	endfunction
	task check_pins(input logic [3:0] x);
		n_tests++;
		if (rx_status_pin !== x) begin
			err_count++;
			$display("BAD rx_status_pin exp %h got %h", x, rx_status_pin);
		end
	endtask
	task check_mode(input logic x);
		n_tests++;
		if (line_enable_mode !== x) begin
			err_count++;
			$display("BAD line_enable_mode exp %h got %h", x, line_enable_mode);
		end
	endtask
	// One new input set every cycle; the watcher relies on that pace
	task drive(input logic [7:0] c);
		seed = lfsr(seed);
		@(posedge clock);
		ctrl <= c;
		rdy_req <= seed[3:0];
		rcv_req <= seed[7:4];
		exp_q.push_back(model(c, seed[3:0], seed[7:4]));
	endtask
	task results;
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Watcher: the note two deep is the one now on the outputs
	// ------------------------------------------------------------
	always @(negedge clock) begin
		if (rst_b === 1'b1 && exp_q.size() == 2) begin
			e = exp_q.pop_front();
			check_pins(e[3:0]);
			check_mode(e[4]);
		end
	end

	// Watchdog well past the few hundred cycles of stimulus
	initial begin
		#100000;
		err_count++;
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		ctrl = 8'h00;
		rdy_req = 4'h0;
		rcv_req = 4'h0;
		repeat (11) @(posedge clock);
		#1 check_pins(4'hf);
		check_mode(1'b0);
		@(posedge clock);
		rst_b <= 1'b1;
		// Every mode, toggle and level, junk in bits 5:2
		for (int i = 0; i < 32; i++) begin
			drive({i[3:2], seed[11:8], i[1:0]});
		end
		// Enable mode held in spans of 16: toggling then static, both levels
		for (int i = 0; i < 64; i++) begin
			drive({i[4], ~i[5], (i[3] ? seed[13:10] : 4'h0), 2'h3});
		end
		// Reset asserted at an edge sets the pins high in that same step
		@(posedge clock);
		rst_b <= 1'b0;
		exp_q.delete();
		#1 check_pins(4'hf);
		check_mode(1'b0);
		@(posedge clock);
		rst_b <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			drive(seed[15:8]);
		end
		drive(8'h00);
		drive(8'h00);
		@(posedge clock);
		results();
	end
endmodule
